// File: tb_top.sv
`timescale 1ns/10ps

module tb_top;
  import tic_pkg::*;

  logic        core_clk       = 1'b0;
  logic        rst_b          = 1'b0;
  logic        capPin;
  logic        waitMode       = 1'b0;
  logic        haltMode       = 1'b0;
  logic        activeHaltMode = 1'b0;
  logic        cpuIrqMask     = 1'b1;
  logic        irqCapCmp, irqOvf, irq, wakeUp;
  logic [7:0]  awaddr         = 8'h00;
  logic [7:0]  araddr         = 8'h00;
  logic        awvalid        = 1'b0;
  logic        wvalid         = 1'b0;
  logic        bready         = 1'b0;
  logic        arvalid        = 1'b0;
  logic        rready         = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata          = 32'h0;
  logic [3:0]  wstrb          = 4'hf;
  logic [31:0] rdata, rd, c1, c3;
  logic [1:0]  bresp, rresp;
  int          n_errors       = 0;
  int          checks         = 0;
  logic [7:0]  rstAddr [8]    = '{TIC_ADDR_CTRL, TIC_ADDR_STATUS,
    TIC_ADDR_IRQ_EN, TIC_ADDR_CAP_HIGH, TIC_ADDR_CAP_LOW,
    TIC_ADDR_COUNTER, TIC_ADDR_RELOAD, TIC_ADDR_COMPARE};
  logic [31:0] rstVal [8]     = '{32'(TIC_CTRL_RST), 32'(TIC_FLG_RST),
    32'h0, 32'h0, 32'h0, 32'(TIC_CNT_RST), 32'(TIC_RELOAD_RST),
    32'(TIC_CMP_RST)};

  always #10 core_clk = ~core_clk;

  tic_pin_source src_u (.core_clk(core_clk), .pinLevel(capPin));

  tic_capture_irq dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .capture_input_pin(capPin),
    .waitMode(waitMode), .haltMode(haltMode),
    .activeHaltMode(activeHaltMode), .cpuIrqMask(cpuIrqMask),
    .irqCapCmp(irqCapCmp), .irqOvf(irqOvf), .irq(irq), .wakeUp(wakeUp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is sampled mid-cycle so the edge that takes it is known
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    logic awHit, wHit, awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(negedge core_clk);
      awHit = awvalid && awready;
      wHit = wvalid && wready;
      @(posedge core_clk);
      if (awHit) begin
        awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (wHit) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    bready <= 1'b1;
    do @(negedge core_clk); while (bvalid !== 1'b1);
    chk("bresp", 32'(bresp), 32'(er));
    @(posedge core_clk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [1:0] er,
                          output logic [31:0] d);
    logic hit;
    hit = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!hit) begin
      @(negedge core_clk);
      hit = arready;
      @(posedge core_clk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    chk("rresp", 32'(rresp), 32'(er));
    @(posedge core_clk);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, TIC_RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, TIC_RESP_OKAY, rd);
    chk($sformatf("rdata_%h", a), rd, exp);
  endtask

  // Leaves the bench at the falling edge; outputs are settled there
  task automatic set_modes(input logic w, ah, h);
    waitMode <= w;
    activeHaltMode <= ah;
    haltMode <= h;
    @(negedge core_clk);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    foreach (rstAddr[i]) rd_chk(rstAddr[i], rstVal[i]);
    axi_read(8'h20, TIC_RESP_SLVERR, rd);
    chk("unmapped", rd, 32'h0);
    axi_write(8'h20, 32'h1, TIC_RESP_SLVERR);
    // Only byte lane 0 is enabled, the upper compare bits must stay
    wstrb <= 4'h1;
    wr(TIC_ADDR_COMPARE, 32'h0123);
    wstrb <= 4'hf;
    rd_chk(TIC_ADDR_COMPARE, 32'({TIC_CMP_RST[11:8], 8'h23}));
    wr(TIC_ADDR_COMPARE, 32'(TIC_CMP_RST));
    rd_chk(TIC_ADDR_COMPARE, 32'(TIC_CMP_RST));
    $display("test reset done");

    wr(TIC_ADDR_CTRL, 32'h1);
    set_modes(1'b1, 1'b0, 1'b0);
    @(posedge core_clk);
    axi_read(TIC_ADDR_COUNTER, TIC_RESP_OKAY, c1);
    axi_read(TIC_ADDR_COUNTER, TIC_RESP_OKAY, rd);
    chk("waitCounting", 32'(rd != c1), 32'h1);
    set_modes(1'b0, 1'b0, 1'b1);
    @(posedge core_clk);
    axi_read(TIC_ADDR_COUNTER, TIC_RESP_OKAY, c1);
    rd_chk(TIC_ADDR_COUNTER, c1);
    $display("test modes done");

    src_u.set_level(1'b1);
    rd_chk(TIC_ADDR_STATUS, 32'h1);
    chk("irqNoEnable", irqCapCmp, 32'h0);
    wr(TIC_ADDR_IRQ_EN, 32'h1);
    chk("irqMasked", irq, 32'h0);
    cpuIrqMask <= 1'b0;
    @(negedge core_clk);
    chk("irqCapCmp", irqCapCmp, 32'h1);
    chk("irqOvfIdle", irqOvf, 32'h0);
    @(posedge core_clk);
    set_modes(1'b0, 1'b0, 1'b0);
    @(posedge core_clk);
    src_u.set_level(1'b0);
    src_u.set_level(1'b1);
    set_modes(1'b0, 1'b0, 1'b1);
    @(posedge core_clk);
    rd_chk(TIC_ADDR_CAP_HIGH, {28'h0, c1[11:8]});
    rd_chk(TIC_ADDR_CAP_LOW, {24'h0, c1[7:0]});
    rd_chk(TIC_ADDR_STATUS, 32'h0);
    chk("irqCleared", irqCapCmp, 32'h0);
    wr(TIC_ADDR_CAP_LOW, 32'h55);
    rd_chk(TIC_ADDR_CAP_LOW, {24'h0, c1[7:0]});
    axi_read(TIC_ADDR_COUNTER, TIC_RESP_OKAY, c3);
    wr(TIC_ADDR_CTRL, 32'h3);
    src_u.set_level(1'b0);
    rd_chk(TIC_ADDR_STATUS, 32'h1);
    rd_chk(TIC_ADDR_CAP_LOW, {24'h0, c3[7:0]});
    src_u.set_level(1'b1);
    rd_chk(TIC_ADDR_STATUS, 32'h0);
    $display("test capture done");

    wr(TIC_ADDR_RELOAD, 32'hff0);
    set_modes(1'b0, 1'b0, 1'b0);
    @(posedge core_clk);
    wr(TIC_ADDR_CTRL, 32'h1);
    // Long enough for the first wrap and two short reloads after it
    repeat (4300) @(posedge core_clk);
    wr(TIC_ADDR_CTRL, 32'h0);
    rd_chk(TIC_ADDR_STATUS, 32'he);
    src_u.set_level(1'b0);
    src_u.set_level(1'b1);
    rd_chk(TIC_ADDR_STATUS, 32'hf);
    for (int b = 0; b < 4; b++) begin
      wr(TIC_ADDR_IRQ_EN, 32'(1 << b));
      set_modes(1'b0, 1'b0, 1'b1);
      chk("wakeHalt", wakeUp, 32'h0);
      @(posedge core_clk);
      set_modes(1'b0, 1'b1, 1'b0);
      chk("wakeActHalt", wakeUp, 32'(b == TIC_FLG_FIRST_OVERFLOW_FLAG));
      @(posedge core_clk);
      set_modes(1'b1, 1'b0, 1'b0);
      chk("wakeWait", wakeUp, 32'h1);
      chk("vecCapCmp", irqCapCmp,
          32'(b == TIC_FLG_CAP || b == TIC_FLG_CMP));
      chk("vecOvf", irqOvf,
          32'(b == TIC_FLG_FIRST_OVERFLOW_FLAG || b == TIC_FLG_SECOND_OVERFLOW_FLAG));
      @(posedge core_clk);
    end
    cpuIrqMask <= 1'b1;
    @(negedge core_clk);
    chk("irqMaskedCmp", irq, 32'h0);
    @(posedge core_clk);
    wr(TIC_ADDR_STATUS, 32'hf);
    rd_chk(TIC_ADDR_STATUS, 32'h0);
    $display("test events done");
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
endmodule

// File: tic_capture_irq.sv
// Operation
// - An edge on the capture pin copies the 12-bit counter into the capture register.
// - Each capture sets the capture flag and leaves the taken value in the register.
// - A set capture flag with its enable set requests the capture interrupt.
// - Reading the high or low capture byte while the flag is set clears the flag.
// - The capture register is read only and holds the latest accepted capture.
// - While the capture flag is set, further edges are ignored, except in the cycle of a capture read.
// - The counter keeps running in wait mode and stops in halt mode.
// - First overflow sets its flag and wakes from wait and active-halt, not halt.
// - Compare sets its flag and wakes from wait only.
// - Capture and second overflow wake from wait only.
// - Compare and capture share one vector; overflows use another.
// - An interrupt is raised only if enabled and the global mask is clear.
`timescale 1ns/10ps

module tic_capture_irq
  import tic_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              capture_input_pin,
  input  wire logic              waitMode,
  input  wire logic              haltMode,
  input  wire logic              activeHaltMode,
  input  wire logic              cpuIrqMask,
  output logic                   irqCapCmp,
  output logic                   irqOvf,
  output logic                   irq,
  output logic                   wakeUp,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] strbMask(input logic [3:0] strb);
    strbMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == TIC_ADDR_CTRL)     || (a == TIC_ADDR_STATUS)   ||
               (a == TIC_ADDR_IRQ_EN)   || (a == TIC_ADDR_CAP_HIGH) ||
               (a == TIC_ADDR_CAP_LOW)  || (a == TIC_ADDR_COUNTER)  ||
               (a == TIC_ADDR_RELOAD)   || (a == TIC_ADDR_COMPARE);
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic [TIC_CTRL_W-1:0] ctrl;
  logic [TIC_FLG_W-1:0]  flags;
  logic [TIC_FLG_W-1:0]  irqEn;
  logic [TIC_CNT_W-1:0]  free_running_counter;
  logic [TIC_CNT_W-1:0]  capture_value_reg;
  logic [TIC_CNT_W-1:0]  reloadValue;
  logic [TIC_CNT_W-1:0]  compareValue;
  logic                  ovfPhase;
  logic                  capEdge;
  logic                  capAccept;
  logic                  capRead;
  logic                  counting;
  logic                  ovf1Event;
  logic                  cmpEvent;
  logic [TIC_FLG_W-1:0]  setFlags;
  logic [TIC_FLG_W-1:0]  clrFlags;
  logic [TIC_FLG_W-1:0]  pending;
  logic                  awHeld;
  logic                  wHeld;
  logic [7:0]            wAddr;
  logic [31:0]           wData;
  logic [3:0]            wStrb;
  logic                  doWrite;
  logic [31:0]           wMask;
  logic [7:0]            rAddr;
  logic                  arTake;
  logic [31:0]           next_rdata;

  // ****************************************
  // Capture input
  // ****************************************
  tic_edge_detect #(
    .SYNC_STAGES (2)
  ) u_edge (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .pinIn      (capture_input_pin),
    .fallingSel (ctrl[TIC_CTRL_FALLING]),
    .edgeSeen   (capEdge)
  );

  // A read that clears the flag in this same cycle lets the edge through
  assign capAccept = capEdge &
                     (~flags[TIC_FLG_CAP] | capRead);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_value_reg <= TIC_CNT_RST;
    end else if (capAccept) begin
      capture_value_reg <= free_running_counter;
    end
  end

  // ****************************************
  // Free-running counter
  // ****************************************
  assign counting  = ctrl[TIC_CTRL_RUN] & ~haltMode;
  assign ovf1Event = counting & (free_running_counter == TIC_CNT_TOP);
  assign cmpEvent  = counting & (free_running_counter == compareValue);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      free_running_counter <= TIC_CNT_RST;
    end else if (ovf1Event) begin
      free_running_counter <= reloadValue;
    end else if (counting) begin
      free_running_counter <= free_running_counter + 12'h001;
    end
  end

  // Second overflow marks every other first overflow
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovfPhase <= 1'b0;
    end else if (ovf1Event) begin
      ovfPhase <= ~ovfPhase;
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  always_comb begin
    setFlags               = '0;
    setFlags[TIC_FLG_CAP]  = capAccept;
    setFlags[TIC_FLG_FIRST_OVERFLOW_FLAG] = ovf1Event;
    setFlags[TIC_FLG_SECOND_OVERFLOW_FLAG] = ovf1Event & ovfPhase;
    setFlags[TIC_FLG_CMP]  = cmpEvent;
  end

  always_comb begin
    clrFlags = '0;
    if (doWrite && wAddr == TIC_ADDR_STATUS) begin
      clrFlags = wData[TIC_FLG_W-1:0] & wMask[TIC_FLG_W-1:0];
    end
    clrFlags[TIC_FLG_CAP] = clrFlags[TIC_FLG_CAP] | capRead;
  end

  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= TIC_FLG_RST;
    end else begin
      flags <= (flags & ~clrFlags) | setFlags;
    end
  end

  // ****************************************
  // Interrupts and wake-up
  // ****************************************
  assign pending   = flags & irqEn;
  assign irqCapCmp = ~cpuIrqMask &
                     (pending[TIC_FLG_CAP] | pending[TIC_FLG_CMP]);
  assign irqOvf    = ~cpuIrqMask &
                     (pending[TIC_FLG_FIRST_OVERFLOW_FLAG] | pending[TIC_FLG_SECOND_OVERFLOW_FLAG]);
  assign irq       = irqCapCmp | irqOvf;

  // Halt wins when the mode inputs overlap; only overflow 1 leaves active-halt
  always_comb begin
    if (haltMode) begin
      wakeUp = 1'b0;
    end else if (activeHaltMode) begin
      wakeUp = pending[TIC_FLG_FIRST_OVERFLOW_FLAG];
    end else begin
      wakeUp = waitMode & (|pending);
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
  assign doWrite       = awHeld & wHeld & ~s_axi_bvalid;
  assign wMask         = strbMask(wStrb);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wAddr  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      wAddr  <= {s_axi_awaddr[7:2], 2'h0};
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TIC_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= isMapped(wAddr) ? TIC_RESP_OKAY : TIC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Capture and counter words ignore writes; status bits are cleared by writing ones
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl         <= TIC_CTRL_RST;
      irqEn        <= TIC_FLG_RST;
      reloadValue  <= TIC_RELOAD_RST;
      compareValue <= TIC_CMP_RST;
    end else if (doWrite) begin
      case (wAddr)
        TIC_ADDR_CTRL: begin
          ctrl <= (ctrl & ~wMask[TIC_CTRL_W-1:0]) |
                  (wData[TIC_CTRL_W-1:0] & wMask[TIC_CTRL_W-1:0]);
        end
        TIC_ADDR_IRQ_EN: begin
          irqEn <= (irqEn & ~wMask[TIC_FLG_W-1:0]) |
                   (wData[TIC_FLG_W-1:0] & wMask[TIC_FLG_W-1:0]);
        end
        TIC_ADDR_RELOAD: begin
          reloadValue <= (reloadValue & ~wMask[TIC_CNT_W-1:0]) |
                         (wData[TIC_CNT_W-1:0] & wMask[TIC_CNT_W-1:0]);
        end
        TIC_ADDR_COMPARE: begin
          compareValue <= (compareValue & ~wMask[TIC_CNT_W-1:0]) |
                          (wData[TIC_CNT_W-1:0] & wMask[TIC_CNT_W-1:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = ~s_axi_rvalid;
  assign arTake        = s_axi_arvalid & s_axi_arready;
  assign rAddr         = {s_axi_araddr[7:2], 2'h0};
  assign capRead       = arTake & flags[TIC_FLG_CAP] &
                         ((rAddr == TIC_ADDR_CAP_HIGH) ||
                          (rAddr == TIC_ADDR_CAP_LOW));

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (rAddr)
      TIC_ADDR_CTRL:     next_rdata[TIC_CTRL_W-1:0] = ctrl;
      TIC_ADDR_STATUS:   next_rdata[TIC_FLG_W-1:0]  = flags;
      TIC_ADDR_IRQ_EN:   next_rdata[TIC_FLG_W-1:0]  = irqEn;
      TIC_ADDR_CAP_HIGH: next_rdata[TIC_CNT_W-TIC_LOW_W-1:0] =
                           capture_value_reg[TIC_CNT_W-1:TIC_LOW_W];
      TIC_ADDR_CAP_LOW:  next_rdata[TIC_LOW_W-1:0] =
                           capture_value_reg[TIC_LOW_W-1:0];
      TIC_ADDR_COUNTER:  next_rdata[TIC_CNT_W-1:0] = free_running_counter;
      TIC_ADDR_RELOAD:   next_rdata[TIC_CNT_W-1:0] = reloadValue;
      TIC_ADDR_COMPARE:  next_rdata[TIC_CNT_W-1:0] = compareValue;
      default:           next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= TIC_RESP_OKAY;
    end else if (arTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= isMapped(rAddr) ? TIC_RESP_OKAY : TIC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_cap_loads: assert property (@(posedge core_clk) disable iff (!rst_b)
    capAccept |=> capture_value_reg == $past(free_running_counter))
    else $error("capture did not take the counter value");

  a_flag_sets: assert property (@(posedge core_clk) disable iff (!rst_b)
    capAccept |=> flags[TIC_FLG_CAP])
    else $error("capture did not set the capture flag");

  a_cap_irq_req: assert property (@(posedge core_clk) disable iff (!rst_b)
    (flags[TIC_FLG_CAP] && irqEn[TIC_FLG_CAP] && !cpuIrqMask) |-> irqCapCmp)
    else $error("pending capture gave no interrupt");

  a_read_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
    (capRead && !capEdge) |=> !flags[TIC_FLG_CAP])
    else $error("capture read did not clear the flag");

  a_cap_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
    !capAccept |=> $stable(capture_value_reg))
    else $error("capture register changed without capture");

  // A capture read can admit an edge in its own cycle, so only cycles without one are held
  a_cap_blocked: assert property (@(posedge core_clk) disable iff (!rst_b)
    (flags[TIC_FLG_CAP] && !capRead) |=> $stable(capture_value_reg))
    else $error("capture taken while flag pending");

  a_halt_stops: assert property (@(posedge core_clk) disable iff (!rst_b)
    haltMode |=> $stable(free_running_counter))
    else $error("counter moved in halt");

  a_halt_nowake: assert property (@(posedge core_clk) disable iff (!rst_b)
    haltMode |-> !wakeUp)
    else $error("wake-up raised in halt");

  a_ahalt_wake: assert property (@(posedge core_clk) disable iff (!rst_b)
    (activeHaltMode && !haltMode) |-> wakeUp == pending[TIC_FLG_FIRST_OVERFLOW_FLAG])
    else $error("active-halt wake-up from wrong source");

  a_wait_wake: assert property (@(posedge core_clk) disable iff (!rst_b)
    (waitMode && !haltMode && !activeHaltMode && pending[TIC_FLG_SECOND_OVERFLOW_FLAG])
      |-> wakeUp)
    else $error("second overflow did not wake from wait");

  a_vector_split: assert property (@(posedge core_clk) disable iff (!rst_b)
    (pending[TIC_FLG_CMP] && !cpuIrqMask) |-> irqCapCmp)
    else $error("compare not on the capture vector");

  a_global_mask: assert property (@(posedge core_clk) disable iff (!rst_b)
    cpuIrqMask |-> !(irqCapCmp || irqOvf || irq))
    else $error("interrupt raised while globally masked");

  a_edge_default: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(rst_b) |-> !ctrl[TIC_CTRL_FALLING])
    else $error("edge select not rising after reset");

endmodule

// File: tic_edge_detect.sv
`timescale 1ns/10ps

module tic_edge_detect #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic pinIn,
  input  wire logic fallingSel,
  output logic      edgeSeen
);

  // ****************************************
  // Synchroniser, first stage read only by the next
  // ****************************************
  logic [SYNC_STAGES-1:0] syncChain;
  logic                   lastLevel;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncChain <= '0;
    end else begin
      syncChain <= {syncChain[SYNC_STAGES-2:0], pinIn};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lastLevel <= 1'b0;
    end else begin
      lastLevel <= syncChain[SYNC_STAGES-1];
    end
  end

  // Polarity chosen by software; rising by default
  assign edgeSeen = fallingSel ?
                    (lastLevel & ~syncChain[SYNC_STAGES-1]) :
                    (~lastLevel & syncChain[SYNC_STAGES-1]);

endmodule

// File: tic_pin_source.sv
`timescale 1ns/10ps

// ****************************************
// Capture pin source
// ****************************************
module tic_pin_source (
  input  wire logic core_clk,
  output logic      pinLevel
);
  initial pinLevel = 1'b0;

  // Each level stands 4 clocks, longer than the synchroniser needs
  task automatic set_level(input logic v);
    @(posedge core_clk);
    pinLevel <= v;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// File: tic_pkg.sv
package tic_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] TIC_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] TIC_ADDR_STATUS   = 8'h04;
  localparam logic [7:0] TIC_ADDR_IRQ_EN   = 8'h08;
  localparam logic [7:0] TIC_ADDR_CAP_HIGH = 8'h0c;
  localparam logic [7:0] TIC_ADDR_CAP_LOW  = 8'h10;
  localparam logic [7:0] TIC_ADDR_COUNTER  = 8'h14;
  localparam logic [7:0] TIC_ADDR_RELOAD   = 8'h18;
  localparam logic [7:0] TIC_ADDR_COMPARE  = 8'h1c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TIC_CTRL_RUN     = 0;
  localparam int TIC_CTRL_FALLING = 1;
  localparam int TIC_CTRL_W       = 2;

  localparam int TIC_FLG_CAP  = 0;
  localparam int TIC_FLG_FIRST_OVERFLOW_FLAG = 1;
  localparam int TIC_FLG_SECOND_OVERFLOW_FLAG = 2;
  localparam int TIC_FLG_CMP  = 3;
  localparam int TIC_FLG_W    = 4;

  localparam int TIC_CNT_W = 12;
  localparam int TIC_LOW_W = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [TIC_CTRL_W-1:0] TIC_CTRL_RST   = 2'h0;
  localparam logic [TIC_FLG_W-1:0]  TIC_FLG_RST    = 4'h0;
  localparam logic [TIC_CNT_W-1:0]  TIC_CNT_RST    = 12'h000;
  localparam logic [TIC_CNT_W-1:0]  TIC_RELOAD_RST = 12'h000;
  localparam logic [TIC_CNT_W-1:0]  TIC_CMP_RST    = 12'hfff;
  localparam logic [TIC_CNT_W-1:0]  TIC_CNT_TOP    = 12'hfff;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] TIC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TIC_RESP_SLVERR = 2'h2;

endpackage
